// ==== common/spd_pkg.sv ====
// Constants, register map and carrier types of the speed and direction pulse encoder
// Overview of operation
// - After power-on, first valid direction pulse within four target cycles of steady rotation.
// - Running mode ignores oscillation: one cycle (high immunity) or 0.12 cycle (low).
// - Channel one is element one minus two, channel two is two minus three.
// - Track positive and negative peaks per channel, derive adaptive switch thresholds.
// - Output edge launched only when the differential field crosses a threshold.
// - Exactly one output pulse per pole pair or tooth-and-gap pair; the code gives none for a trigger during a running pulse or while blanking.
// - Pulse rate carries speed, pulse width carries direction; receiver decodes both.
// - Feature moving lead one to lead two gives forward width, else reverse width.
// - Reverse orientation option swaps the direction sense.
// - Intermediate option in high-speed mode uses high-speed width for both directions.
// - Operate threshold near 75 percent, release near 25 percent of peak-to-peak.
// - Narrow widths: forward 45 us, reverse 90 us, non-direction 180 us.
// - Intermediate option drops direction above the high-speed frequency limit.
`default_nettype none
package spd_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FWD_WIDTH_US  = 45;
  localparam int REV_WIDTH_US  = 90;
  localparam int ND_WIDTH_US   = 180;
  localparam int HS_WIDTH_US   = 30;
  localparam int FWD_CYCLES    = FWD_WIDTH_US * 1000 / CLK_PERIOD_NS;
  localparam int REV_CYCLES    = REV_WIDTH_US * 1000 / CLK_PERIOD_NS;
  localparam int ND_CYCLES     = ND_WIDTH_US * 1000 / CLK_PERIOD_NS;
  localparam int HS_CYCLES     = HS_WIDTH_US * 1000 / CLK_PERIOD_NS;

  localparam int SMP_W  = 12;
  localparam int DIFF_W = 13;
  localparam int TH_W   = 15;
  localparam int TMR_W  = 16;
  localparam int PER_W  = 20;

  localparam logic [TH_W-1:0]  SPAN_MIN         = 15'h0020;
  localparam logic [PER_W-1:0] HS_LIMIT_RESET   = 20'h0208D;
  localparam logic [PER_W-1:0] PER_MAX          = 20'hFFFFF;
  localparam logic [1:0]       CONFIRM_HIGH_VIB = 2'h2;
  localparam logic [1:0]       CONFIRM_LOW_VIB  = 2'h1;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_HSLIMIT = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_PULSES  = 8'h0C;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic                    valid;
    logic signed [SMP_W-1:0] senseElementOne;
    logic signed [SMP_W-1:0] senseElementTwo;
    logic signed [SMP_W-1:0] senseElementThree;
  } spd_sample_t;

  typedef struct packed {
    logic highVib;
    logic midWidth;
    logic revOrient;
    logic enable;
  } spd_ctrl_t;

  localparam spd_ctrl_t CTRL_RESET = 4'h1;
endpackage : spd_pkg
`default_nettype wire

// ==== rtl/spd_channel.sv ====
// One differential channel: peak tracking, adaptive thresholds, hysteretic switching
`timescale 1ns/1ps
`default_nettype none
module spd_channel import spd_pkg::*; (
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     smpValid,
  input  wire logic signed [DIFF_W-1:0] differentialField,
  output var  logic                     level,
  output var  logic                     rise,
  output var  logic                     fall,
  output var  logic                     ready
);
  logic signed [TH_W-1:0] diffX, peakMax, peakMin, runMax, runMin;
  logic signed [TH_W-1:0] span, quarter, operateThreshold, releaseThreshold;
  logic                   seenRise;

  assign diffX            = TH_W'(differentialField);
  assign span             = peakMax - peakMin;
  assign quarter          = span >>> 2;
  assign operateThreshold = peakMin + span - quarter;
  assign releaseThreshold = peakMin + quarter;

  // Small spans are noise; no switching until the signal is large enough
  logic canSwitch;
  assign canSwitch = smpValid && (span >= $signed(SPAN_MIN));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (canSwitch && !level && diffX > operateThreshold) begin
        level <= 1'b1;
        rise  <= 1'b1;
      end else if (canSwitch && level && diffX < releaseThreshold) begin
        level <= 1'b0;
        fall  <= 1'b1;
      end
    end
  end

  // Peaks widen at once, and are re-committed from the last half cycle at each switch
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      peakMax <= '0;
      peakMin <= '0;
      runMax  <= '0;
      runMin  <= '0;
    end else if (smpValid) begin
      if (rise) begin
        peakMin <= runMin;
        runMax  <= diffX;
      end else if (fall) begin
        peakMax <= runMax;
        runMin  <= diffX;
      end else begin
        if (diffX > peakMax) peakMax <= diffX;
        if (diffX < peakMin) peakMin <= diffX;
        if (diffX > runMax) runMax <= diffX;
        if (diffX < runMin) runMin <= diffX;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seenRise <= 1'b0;
      ready    <= 1'b0;
    end else begin
      if (rise) seenRise <= 1'b1;
      if (fall && seenRise) ready <= 1'b1;
    end
  end

  chk_op_above_rp: assert property (@(posedge mclk) disable iff (!rstn)
    span >= 0 |-> operateThreshold >= releaseThreshold)
    else $error("operate threshold below release threshold");
  chk_switch_on_cross: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(level) |-> $past(diffX) > $past(operateThreshold))
    else $error("channel switched high without crossing operate threshold");
endmodule : spd_channel
`default_nettype wire

// ==== rtl/spd_encoder.sv ====
// Speed and direction pulse encoder core with AXI4-Lite control registers
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module spd_encoder import spd_pkg::*; #(
  parameter int FWD_CYC = FWD_CYCLES,
  parameter int REV_CYC = REV_CYCLES,
  parameter int ND_CYC  = ND_CYCLES,
  parameter int HS_CYC  = HS_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire spd_sample_t sample,
  output var  logic        pulseOut,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  spd_ctrl_t          ctrl;
  logic [PER_W-1:0]   hsLimit;
  logic [31:0]        pulseCount;
  logic [7:0]         awAddr;
  logic [31:0]        wData;
  logic [3:0]         wStrb;
  logic               awHeld, wHeld;

  // Differential channels
  logic signed [DIFF_W-1:0] chDiff [2];
  logic [1:0] chLevel, chRise, chFall, chReady;

  assign chDiff[0] = DIFF_W'(sample.senseElementOne) - DIFF_W'(sample.senseElementTwo);
  assign chDiff[1] = DIFF_W'(sample.senseElementTwo) - DIFF_W'(sample.senseElementThree);

  // Each channel is evaluated on its own
  for (genvar c = 0; c < 2; c++) begin : gChan
    spd_channel uChan (
      .mclk              (mclk),
      .rstn              (rstn),
      .smpValid          (sample.valid),
      .differentialField (chDiff[c]),
      .level             (chLevel[c]),
      .rise              (chRise[c]),
      .fall              (chFall[c]),
      .ready             (chReady[c])
    );
  end

  // Edge processing: one trigger per channel-one rising crossing, so one per target cycle
  logic             procEdge, dirNow, dirFlip, launch, dirValid, useHs;
  logic             havePrev, lastDir, calibrated, hsMode, blanking;
  logic [1:0]       confirm;
  logic [PER_W-1:0] periodCnt;
  logic [TMR_W-1:0] pulseTimer, selWidth, curWidth;
  logic             curFwd;

  assign procEdge = chRise[0] && ctrl.enable && (&chReady);
  // Channel one leads when a feature runs lead one to lead two, so channel two is still low
  assign dirNow   = ~chLevel[1] ^ ctrl.revOrient;
  assign dirFlip  = procEdge && havePrev && (dirNow != lastDir);
  assign dirValid = havePrev && !dirFlip;
  assign launch   = procEdge && (!havePrev || (dirValid && confirm == 2'h0));
  assign useHs    = ctrl.midWidth && hsMode;

  always_comb begin
    if (useHs) begin
      selWidth = TMR_W'(HS_CYC);
    end else if (!havePrev) begin
      selWidth = TMR_W'(ND_CYC);
    end else if (dirNow) begin
      selWidth = TMR_W'(FWD_CYC);
    end else begin
      selWidth = TMR_W'(REV_CYC);
    end
  end

  // Period between triggers decides high-speed mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      periodCnt <= PER_MAX;
      hsMode    <= 1'b0;
    end else if (procEdge) begin
      periodCnt <= '0;
      hsMode    <= periodCnt < hsLimit;
    end else if (periodCnt != PER_MAX) begin
      periodCnt <= periodCnt + 1'b1;
    end
  end

  // Direction tracking and vibration blanking
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      havePrev   <= 1'b0;
      lastDir    <= 1'b0;
      confirm    <= '0;
      calibrated <= 1'b0;
    end else if (!ctrl.enable) begin
      havePrev   <= 1'b0;
      confirm    <= '0;
      calibrated <= 1'b0;
    end else if (procEdge) begin
      havePrev <= 1'b1;
      lastDir  <= dirNow;
      if (dirFlip) begin
        // High immunity waits a full extra cycle before trusting the new direction
        confirm <= ctrl.highVib ? CONFIRM_HIGH_VIB : CONFIRM_LOW_VIB;
      end else if (havePrev && confirm != 2'h0) begin
        confirm <= confirm - 1'b1;
      end
      if (launch && havePrev) calibrated <= 1'b1;
    end
  end

  assign blanking = confirm != 2'h0;

  // Pulse timer; a trigger during a running pulse is dropped to keep widths readable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulseOut   <= 1'b0;
      pulseTimer <= '0;
      curWidth   <= '0;
      curFwd     <= 1'b0;
    end else if (launch && !pulseOut) begin
      pulseOut   <= 1'b1;
      pulseTimer <= selWidth;
      curWidth   <= selWidth;
      curFwd     <= dirNow;
    end else if (pulseOut) begin
      pulseTimer <= pulseTimer - 1'b1;
      if (pulseTimer == TMR_W'(1)) pulseOut <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulseCount <= '0;
    end else if (launch && !pulseOut) begin
      pulseCount <= pulseCount + 1'b1;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic wrHit;
  assign wrHit = awAddr == OFS_CTRL || awAddr == OFS_HSLIMIT;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= '0;
      wData         <= '0;
      wStrb         <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr        <= s_axi_awaddr;
        awHeld        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        wHeld        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awHeld && wHeld && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awHeld        <= 1'b0;
        wHeld         <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  logic doWrite;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl    <= CTRL_RESET;
      hsLimit <= HS_LIMIT_RESET;
    end else if (doWrite) begin
      if (awAddr == OFS_CTRL && wStrb[0]) ctrl <= spd_ctrl_t'(wData[3:0]);
      if (awAddr == OFS_HSLIMIT) begin
        if (wStrb[0]) hsLimit[7:0]   <= wData[7:0];
        if (wStrb[1]) hsLimit[15:8]  <= wData[15:8];
        if (wStrb[2]) hsLimit[19:16] <= wData[19:16];
      end
    end
  end

  // AXI4-Lite read path
  logic [31:0] rdMux;
  logic        rdHit;

  always_comb begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL:    rdMux = {28'h0, ctrl};
      OFS_HSLIMIT: rdMux = {12'h0, hsLimit};
      OFS_STATUS:  rdMux = {26'h0, chReady[1], blanking, pulseOut, hsMode, lastDir, calibrated};
      OFS_PULSES:  rdMux = pulseCount;
      default: begin
        rdMux = '0;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= rdHit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Helper: triggers seen since both channels became ready without a valid pulse
  logic [3:0] calEdges;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      calEdges <= '0;
    end else if (calibrated || !ctrl.enable) begin
      calEdges <= '0;
    end else if (procEdge && !dirFlip && calEdges != 4'hF) begin
      calEdges <= calEdges + 1'b1;
    end
  end

  sequence sFlip;
    procEdge && dirFlip;
  endsequence
  sequence sLaunchIdle;
    launch && !pulseOut;
  endsequence

  chk_first_pulse_bound: assert property (@(posedge mclk) disable iff (!rstn)
    calEdges <= 4'h2)
    else $error("no valid direction pulse after steady rotation");
  chk_vib_blank: assert property (@(posedge mclk) disable iff (!rstn)
    sFlip |-> !launch ##1 (!ctrl.highVib || confirm == CONFIRM_HIGH_VIB))
    else $error("pulse launched on a direction reversal");
  chk_pulse_on_cross: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(pulseOut) |-> $past(chRise[0]) && $past(ctrl.enable))
    else $error("pulse started without a channel crossing");
  chk_width_end: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(pulseOut) |-> $past(pulseTimer) == TMR_W'(1))
    else $error("pulse ended before its width elapsed");
  chk_fwd_width: assert property (@(posedge mclk) disable iff (!rstn)
    sLaunchIdle ##0 (dirValid && !useHs && dirNow) |=> curFwd && curWidth == TMR_W'(FWD_CYC))
    else $error("forward pulse has wrong width");
  chk_rev_width: assert property (@(posedge mclk) disable iff (!rstn)
    sLaunchIdle ##0 (dirValid && !useHs && !dirNow) |=> curWidth == TMR_W'(REV_CYC))
    else $error("reverse pulse has wrong width");
  chk_orient_sense: assert property (@(posedge mclk) disable iff (!rstn)
    sLaunchIdle ##0 (dirValid && !useHs && chLevel[1] == ctrl.revOrient)
      |=> curWidth == TMR_W'(FWD_CYC))
    else $error("orientation option not applied to direction");
  chk_hs_width: assert property (@(posedge mclk) disable iff (!rstn)
    sLaunchIdle ##0 (ctrl.midWidth && hsMode) |=> curWidth == TMR_W'(HS_CYC))
    else $error("high-speed pulse width not used");
  chk_write_resp: assert property (@(posedge mclk) disable iff (!rstn)
    awHeld && wHeld && !s_axi_bvalid |=> s_axi_bvalid ##0 !s_axi_awready)
    else $error("write response not raised after address and data");
  chk_read_resp: assert property (@(posedge mclk) disable iff (!rstn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not raised after address");
  chk_nd_first: assert property (@(posedge mclk) disable iff (!rstn)
    sLaunchIdle ##0 (!havePrev && !useHs) |=> curWidth == TMR_W'(ND_CYC))
    else $error("first pulse is not non-directional");
  chk_width_load: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(pulseOut) |-> pulseTimer == curWidth)
    else $error("pulse timer not loaded with selected width");
endmodule : spd_encoder
`default_nettype wire

// ==== testbench/spd_receiver.sv ====
// Control-unit model: measures pulse width and spacing on the current line
`timescale 1ns/1ps
`default_nettype none
module spd_receiver (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic pulseIn,
  output var  int   lastWidth,
  output var  int   firstWidth,
  output var  int   nPulses,
  output var  int   lastGap
);
  int   hiCnt;
  int   gapCnt;
  logic prevIn;

  // Width and rise-to-rise spacing decode speed and direction
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lastWidth  <= 0;
      firstWidth <= 0;
      nPulses    <= 0;
      lastGap    <= 0;
      hiCnt      <= 0;
      gapCnt     <= 0;
      prevIn     <= 1'b0;
    end else begin
      prevIn <= pulseIn;
      gapCnt <= gapCnt + 1;
      if (pulseIn) hiCnt <= hiCnt + 1;
      if (pulseIn && !prevIn) begin
        lastGap <= gapCnt;
        gapCnt  <= 1;
      end
      if (!pulseIn && prevIn) begin
        lastWidth <= hiCnt;
        if (nPulses == 0) firstWidth <= hiCnt;
        nPulses <= nPulses + 1;
        hiCnt   <= 0;
      end
    end
  end
endmodule : spd_receiver
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the speed and direction pulse encoder
`timescale 1ns/1ps
`default_nettype none
module tb import spd_pkg::*;;
  // Short widths keep the run small
  localparam int FWD = 8;
  localparam int REV = 16;
  localparam int ND  = 32;
  localparam int HS  = 4;
  localparam int P   = 64;
  localparam int A   = 400;

  logic        mclk;
  logic        rstn;
  spd_sample_t sample;
  logic        pulseOut;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          lastWidth, firstWidth, nPulses, lastGap;
  int          nErrors, testsRun, pos;

  spd_encoder #(.FWD_CYC(FWD), .REV_CYC(REV), .ND_CYC(ND), .HS_CYC(HS)) dut (
    .mclk(mclk), .rstn(rstn), .sample(sample), .pulseOut(pulseOut),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  spd_receiver rx (
    .mclk(mclk), .rstn(rstn), .pulseIn(pulseOut), .lastWidth(lastWidth),
    .firstWidth(firstWidth), .nPulses(nPulses), .lastGap(lastGap)
  );

  always #5 mclk = ~mclk;

  task automatic wrapUp();
    if (nErrors == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrapUp

  task automatic chkBus(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("Error bus at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkBus

  task automatic chkPulse(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("Error pulse at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkPulse

  // Waits for the answer however long it takes; only the watchdog ends a hang
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask : axWrite

  task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : axRead

  task automatic doReset();
    rstn <= 1'b0;
    pos = 0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
  endtask : doReset

  function automatic int triWave(input int p);
    int m;
    m = ((p % P) + P) % P;
    return (m < P / 2) ? -A + 4 * A * m / P : 3 * A - 4 * A * m / P;
  endfunction : triWave

  // Channel two lags channel one for forward travel; common mode is random
  task automatic move(input int n, input int dir);
    int c;
    repeat (n) begin
      @(posedge mclk);
      pos = pos + dir;
      c = int'($urandom_range(1000)) - 500;
      sample.senseElementOne   <= SMP_W'(c + triWave(pos));
      sample.senseElementTwo   <= SMP_W'(c);
      sample.senseElementThree <= SMP_W'(c - triWave(pos - P / 4));
    end
  endtask : move

  function automatic int expWidth(input logic [3:0] c, input logic [19:0] lim, input int dir);
    if (!c[0]) return 0;
    if (c[2] && P < int'(lim)) return HS;
    return ((dir > 0) ^ c[1]) ? FWD : REV;
  endfunction : expWidth

  // Channel two ready stays set; the rest only after a calibrated enabled run
  function automatic logic [31:0] expStatus(input logic [3:0] c, input logic [19:0] lim,
                                            input int dir);
    if (!c[0]) return 32'h0000_0020;
    return {26'h0, 1'b1, 2'b00, (P < int'(lim)), ((dir > 0) ^ c[1]), 1'b1};
  endfunction : expStatus

  // About 40k cycles of tests; the limit leaves margin
  initial begin
    #600_000;
    nErrors++;
    wrapUp();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [19:0] lim;
    int          ew, n0, dir;
    mclk = 1'b0; rstn = 1'b0; sample = '0; sample.valid = 1'b1;
    awaddr = 8'h00; wdata = 32'h0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    wstrb = 4'hF;
    nErrors = 0; testsRun = 0;
    void'($urandom(32'h231A));
    doReset();
    axRead(OFS_CTRL, d, r);
    chkBus(d, 32'(CTRL_RESET));
    axRead(OFS_HSLIMIT, d, r);
    chkBus(d, 32'(HS_LIMIT_RESET));
    axRead(8'h10, d, r);
    chkBus({d[29:0], r}, {30'h0, RESP_DECERR});
    axWrite(OFS_STATUS, 32'h0000_0000, r);
    chkBus(32'(r), 32'(RESP_DECERR));
    lim = 20'($urandom);
    axWrite(OFS_HSLIMIT, {12'h000, lim}, r);
    axRead(OFS_HSLIMIT, d, r);
    chkBus(d, {12'h000, lim});
    // Byte strobes: only the low byte may change
    wstrb <= 4'h1;
    axWrite(OFS_HSLIMIT, 32'h000F_FFA5, r);
    wstrb <= 4'hF;
    axRead(OFS_HSLIMIT, d, r);
    chkBus(d, {12'h000, lim[19:8], 8'hA5});
    // Every option mix, both directions, above and below the speed limit
    for (int c = 0; c < 16; c++) begin
      for (int k = 0; k < 4; k++) begin
        dir = k[0] ? -1 : 1;
        lim = k[1] ? HS_LIMIT_RESET : 20'h00020;
        doReset();
        axWrite(OFS_HSLIMIT, {12'h000, lim}, r);
        axWrite(OFS_CTRL, 32'(c), r);
        move(4 * P, dir);
        ew = expWidth(4'(c), lim, dir);
        if (ew == 0) chkPulse(nPulses, 0);
        else chkPulse(lastWidth, ew);
        n0 = nPulses;
        move(4 * P, dir);
        chkPulse(nPulses - n0, (ew != 0) ? 4 : 0);
        if (ew != 0) begin
          chkPulse(lastGap, P);
          chkPulse(lastWidth, ew);
          if (c[2] == 1'b0) chkPulse(firstWidth, ND);
        end
        axRead(OFS_PULSES, d, r);
        chkBus(d, 32'(nPulses));
        axRead(OFS_STATUS, d, r);
        chkBus(d, expStatus(4'(c), lim, dir));
      end
    end
    // Sub-cycle oscillation must stay silent, then direction pulses resume
    foreach (d[i]) begin
      if (i == 0 || i == 3) begin
        doReset();
        axWrite(OFS_CTRL, (i == 0) ? 32'h1 : 32'h9, r);
        move(6 * P, 1);
        n0 = nPulses;
        repeat (4) begin
          move(58, -1);
          move(58, 1);
        end
        chkPulse(nPulses, n0);
        move(8 * P, 1);
        chkPulse(lastWidth, FWD);
      end
    end
    wrapUp();
  end
endmodule : tb
`default_nettype wire
